/* hdl/pmw_power_ctrl.sv */
`timescale 1ns/1ps
`include "pmw_consts.svh"

module pmw_power_ctrl
  import pmw_pkg::*;
#(
  parameter int XRST_CYCLES = `PMW_XRST_CYC,
  parameter int PULSE_CYCLES = `PMW_PULSE_CYC,
  parameter int SETTLE_CYCLES = `PMW_SETTLE_CYC
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire pmw_host_req_t host_req_i,
  input wire logic wake_frame_evt_i,
  input wire logic energy_evt_i,
  output logic [31:0] host_rdata_o,
  output pmw_state_t power_state_o,
  output logic transceiver_reset_o,
  output logic device_ready_o,
  output logic wake_event_out_o,
  output logic wake_event_oe_o,
  output logic wake_event_interrupt_o
);

  localparam int XW = $clog2(XRST_CYCLES + 1);
  localparam int PW = $clog2(PULSE_CYCLES + 1);
  localparam int SW = $clog2(SETTLE_CYCLES + 1);

  pmw_state_t state_ff, nxt_state;
  logic ready_ff, nxt_ready;
  logic read_seen_ff, nxt_read_seen;
  logic xrst_ff, nxt_xrst;
  logic wake_on_frame_enable_ff, nxt_wake_on_frame_enable;
  logic energy_detect_enable_ff, nxt_energy_detect_enable;
  logic type_ff, nxt_type;
  logic ind_ff, nxt_ind;
  logic pol_ff, nxt_pol;
  logic oen_ff, nxt_oen;
  logic [1:0] cause_ff, nxt_cause;
  logic [31:0] rdata_ff, nxt_rdata;
  logic pin_out_ff, nxt_pin_out;
  logic pin_oe_ff, nxt_pin_oe;
  logic irq_ff, nxt_irq;
  logic [XW-1:0] xrst_len_ff, nxt_xrst_len;

  logic wr_ctrl, rd_any, wr_byte_test, wr_ok;
  logic set_energy, set_frame, active, pulse_start;
  logic xrst_start, xrst_done, pulse_busy, settle_busy, settle_start;
  logic [1:0] cause_clr;
  logic [31:0] ctrl_view;

  assign wr_ctrl = host_req_i.cs && host_req_i.wr &&
                   host_req_i.addr == `PMW_CTRL_OFS;
  assign wr_byte_test = host_req_i.cs && host_req_i.wr &&
                        host_req_i.addr == `PMW_BYTE_TEST_OFS;
  assign rd_any = host_req_i.cs && host_req_i.rd;
  // A write in the same cycle as the first read still counts as early
  assign wr_ok = wr_ctrl && read_seen_ff && ready_ff;

  assign set_energy = energy_detect_enable_ff && energy_evt_i;
  assign set_frame = wake_on_frame_enable_ff && wake_frame_evt_i;

  // Transceiver reset interval
  assign xrst_start = wr_ok && !xrst_ff &&
                      host_req_i.wdata[`PMW_XRST_BIT];
  pmw_timer #(.CYCLES(XRST_CYCLES), .W(XW)) u_xrst_timer (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .start_i(xrst_start),
    .busy_o(),
    .done_o(xrst_done)
  );

  // Wake-up settle interval before the ready flag rises
  assign settle_start = (state_ff != PMW_FULL_POWER) && wr_byte_test;
  pmw_timer #(.CYCLES(SETTLE_CYCLES), .W(SW)) u_settle_timer (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .start_i(settle_start),
    .busy_o(settle_busy),
    .done_o()
  );

  // Pulse starts only on a fresh cause, not on a persisting one
  assign pulse_start = (set_energy && !cause_ff[0]) ||
                       (set_frame && !cause_ff[1]);
  pmw_timer #(.CYCLES(PULSE_CYCLES), .W(PW)) u_pulse_timer (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .start_i(pulse_start),
    .busy_o(pulse_busy),
    .done_o()
  );

  always_comb begin
    ctrl_view = '0;
    ctrl_view[`PMW_MODE_HI:`PMW_MODE_LO] = state_ff;
    ctrl_view[`PMW_XRST_BIT] = xrst_ff;
    ctrl_view[`PMW_WOL_BIT] = wake_on_frame_enable_ff;
    ctrl_view[`PMW_ED_BIT] = energy_detect_enable_ff;
    ctrl_view[`PMW_TYPE_BIT] = type_ff;
    ctrl_view[`PMW_CAUSE_HI:`PMW_CAUSE_LO] = cause_ff;
    ctrl_view[`PMW_IND_BIT] = ind_ff;
    ctrl_view[`PMW_POL_BIT] = pol_ff;
    ctrl_view[`PMW_OEN_BIT] = oen_ff;
    ctrl_view[`PMW_RDY_BIT] = ready_ff;
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_ready = ready_ff;
    nxt_read_seen = read_seen_ff || rd_any;
    nxt_xrst = xrst_ff;
    nxt_wake_on_frame_enable = wake_on_frame_enable_ff;
    nxt_energy_detect_enable = energy_detect_enable_ff;
    nxt_type = type_ff;
    nxt_ind = ind_ff;
    nxt_pol = pol_ff;
    nxt_oen = oen_ff;
    cause_clr = 2'b00;
    nxt_rdata = '0;
    if (rd_any && host_req_i.addr == `PMW_CTRL_OFS) begin
      nxt_rdata = ctrl_view;
    end
    if (settle_start) begin
      nxt_state = PMW_FULL_POWER;
      nxt_read_seen = 1'b0;
    end else if (!settle_busy && !ready_ff &&
                 state_ff == PMW_FULL_POWER) begin
      nxt_ready = 1'b1;
      nxt_read_seen = 1'b0;
    end
    if (xrst_done) begin
      nxt_xrst = 1'b0;
    end
    // Saturates, since a hold longer than the minimum is legal
    nxt_xrst_len = '0;
    if (xrst_ff && xrst_len_ff != XW'(XRST_CYCLES)) begin
      nxt_xrst_len = xrst_len_ff + XW'(1);
    end else if (xrst_ff) begin
      nxt_xrst_len = xrst_len_ff;
    end
    if (wr_ok) begin
      nxt_wake_on_frame_enable = host_req_i.wdata[`PMW_WOL_BIT];
      nxt_energy_detect_enable = host_req_i.wdata[`PMW_ED_BIT];
      nxt_type = host_req_i.wdata[`PMW_TYPE_BIT];
      nxt_ind = host_req_i.wdata[`PMW_IND_BIT];
      nxt_pol = host_req_i.wdata[`PMW_POL_BIT];
      nxt_oen = host_req_i.wdata[`PMW_OEN_BIT];
      cause_clr = host_req_i.wdata[`PMW_CAUSE_HI:`PMW_CAUSE_LO];
      if (xrst_start) begin
        nxt_xrst = 1'b1;
      end
      // The reserved code and the full-power code are refused and the state left as it was
      if (host_req_i.wdata[`PMW_MODE_HI:`PMW_MODE_LO] != 2'b11 &&
          host_req_i.wdata[`PMW_MODE_HI:`PMW_MODE_LO] != 2'b00) begin
        nxt_state = pmw_state_t'(
          host_req_i.wdata[`PMW_MODE_HI:`PMW_MODE_LO]);
        nxt_ready = 1'b0;
      end
    end
    // Event wins over a clear; a live source blocks its clear
    nxt_cause[0] = set_energy ||
                   (cause_ff[0] && !(cause_clr[0] && !energy_evt_i));
    nxt_cause[1] = set_frame ||
                   (cause_ff[1] && !(cause_clr[1] && !wake_frame_evt_i));
  end

  always_comb begin
    active = oen_ff && (ind_ff ? pulse_busy
             : ((cause_ff[0] && energy_detect_enable_ff) ||
                (cause_ff[1] && wake_on_frame_enable_ff)));
    nxt_irq = (cause_ff[0] && energy_detect_enable_ff) ||
              (cause_ff[1] && wake_on_frame_enable_ff);
    if (type_ff) begin
      nxt_pin_oe = 1'b1;
      nxt_pin_out = pol_ff ? active : !active;
    end else begin
      nxt_pin_oe = active;
      nxt_pin_out = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= PMW_FULL_POWER;
      ready_ff <= 1'b0;
      read_seen_ff <= 1'b0;
      xrst_ff <= 1'b0;
      wake_on_frame_enable_ff <= 1'b0;
      energy_detect_enable_ff <= 1'b0;
      type_ff <= 1'b0;
      ind_ff <= 1'b0;
      pol_ff <= 1'b0;
      oen_ff <= 1'b0;
      cause_ff <= 2'b00;
      rdata_ff <= `PMW_CTRL_RESET;
      pin_out_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
      irq_ff <= 1'b0;
      xrst_len_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      ready_ff <= nxt_ready;
      read_seen_ff <= nxt_read_seen;
      xrst_ff <= nxt_xrst;
      wake_on_frame_enable_ff <= nxt_wake_on_frame_enable;
      energy_detect_enable_ff <= nxt_energy_detect_enable;
      type_ff <= nxt_type;
      ind_ff <= nxt_ind;
      pol_ff <= nxt_pol;
      oen_ff <= nxt_oen;
      cause_ff <= nxt_cause;
      rdata_ff <= nxt_rdata;
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
      irq_ff <= nxt_irq;
      xrst_len_ff <= nxt_xrst_len;
    end
  end

  assign host_rdata_o = rdata_ff;
  assign power_state_o = state_ff;
  assign transceiver_reset_o = xrst_ff;
  assign device_ready_o = ready_ff;
  assign wake_event_out_o = pin_out_ff;
  assign wake_event_oe_o = pin_oe_ff;
  assign wake_event_interrupt_o = irq_ff;

  property p_mode_legal;
    @(posedge clock_i) disable iff (!nrst_i) state_ff != PMW_RESERVED;
  endproperty
  a_mode_legal: assert property (p_mode_legal)
    else $error("power state holds reserved code");

  property p_byte_wake;
    @(posedge clock_i) disable iff (!nrst_i)
      (wr_byte_test && state_ff != PMW_FULL_POWER)
      |=> state_ff == PMW_FULL_POWER && !ready_ff;
  endproperty
  a_byte_wake: assert property (p_byte_wake)
    else $error("endian test write did not wake the device");

  property p_xrst_hold;
    @(posedge clock_i) disable iff (!nrst_i)
      $fell(xrst_ff) |-> xrst_len_ff == XW'(XRST_CYCLES);
  endproperty
  a_xrst_hold: assert property (p_xrst_hold)
    else $error("transceiver reset interval wrong");

  property p_xrst_ignore;
    @(posedge clock_i) disable iff (!nrst_i)
      (xrst_ff && !xrst_done) |=> xrst_ff && !$rose(xrst_ff);
  endproperty
  a_xrst_ignore: assert property (p_xrst_ignore)
    else $error("transceiver reset disturbed while high");

  property p_irq_frame;
    @(posedge clock_i) disable iff (!nrst_i)
      (set_frame && wake_on_frame_enable_ff) |=> ##1 wake_event_interrupt_o;
  endproperty
  a_irq_frame: assert property (p_irq_frame)
    else $error("frame wake gave no interrupt");

  property p_irq_energy;
    @(posedge clock_i) disable iff (!nrst_i)
      (set_energy && energy_detect_enable_ff) |=> ##1 wake_event_interrupt_o;
  endproperty
  a_irq_energy: assert property (p_irq_energy)
    else $error("energy wake gave no interrupt");

  property p_cause_both;
    @(posedge clock_i) disable iff (!nrst_i)
      (set_frame && set_energy) |=> cause_ff == 2'b11;
  endproperty
  a_cause_both: assert property (p_cause_both)
    else $error("cause field not multiple on two events");

  property p_cause_held;
    @(posedge clock_i) disable iff (!nrst_i)
      (cause_ff[0] && energy_evt_i) |=> cause_ff[0];
  endproperty
  a_cause_held: assert property (p_cause_held)
    else $error("cause cleared while its source was live");

  property p_open_drain;
    @(posedge clock_i) disable iff (!nrst_i)
      !type_ff ##1 !$past(type_ff) |-> !wake_event_out_o;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain output driven high");

  property p_write_gate;
    @(posedge clock_i) disable iff (!nrst_i)
      (wr_ctrl && !read_seen_ff) |=> $stable(oen_ff) && $stable(wake_on_frame_enable_ff);
  endproperty
  a_write_gate: assert property (p_write_gate)
    else $error("control write took effect before a read");

endmodule : pmw_power_ctrl

/* include/pmw_consts.svh */
`ifndef PMW_CONSTS_SVH
`define PMW_CONSTS_SVH

`define PMW_ADDR_W 8
`define PMW_CTRL_OFS 8'h84
`define PMW_BYTE_TEST_OFS 8'h64

`define PMW_MODE_HI 13
`define PMW_MODE_LO 12
`define PMW_XRST_BIT 10
`define PMW_WOL_BIT 9
`define PMW_ED_BIT 8
`define PMW_TYPE_BIT 6
`define PMW_CAUSE_HI 5
`define PMW_CAUSE_LO 4
`define PMW_IND_BIT 3
`define PMW_POL_BIT 2
`define PMW_OEN_BIT 1
`define PMW_RDY_BIT 0

`define PMW_CTRL_RESET 32'h0000_0000

`define PMW_CLK_MHZ 200
`define PMW_XRST_US 100
`define PMW_PULSE_MS 50
`define PMW_XRST_CYC (`PMW_XRST_US * `PMW_CLK_MHZ)
`define PMW_PULSE_CYC (`PMW_PULSE_MS * 1000 * `PMW_CLK_MHZ)
`define PMW_SETTLE_CYC 16

`endif

/* include/pmw_pkg.sv */
package pmw_pkg;

  typedef enum logic [1:0] {
    PMW_FULL_POWER = 2'b00,
    PMW_PATTERN_WAKE = 2'b01,
    PMW_ENERGY_DETECT = 2'b10,
    PMW_RESERVED = 2'b11
  } pmw_state_t;

  typedef struct packed {
    logic cs;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } pmw_host_req_t;

  typedef struct packed {
    logic out;
    logic oe;
  } pmw_pin_t;

endpackage : pmw_pkg

/* hdl/pmw_timer.sv */
`timescale 1ns/1ps
// One-shot interval counter; start is ignored while running
module pmw_timer #(
  parameter int CYCLES = 16,
  parameter int W = 8
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - W'(1);
    end else if (start_i) begin
      nxt_cnt = W'(CYCLES);
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign busy_o = (cnt_ff != '0);
  assign done_o = (cnt_ff == W'(1));

endmodule : pmw_timer

/* sim/pmw_host_model.sv */
`timescale 1ns/1ps
module pmw_host_model
  import pmw_pkg::*;
(
  input wire logic clock_i,
  output pmw_host_req_t req_o
);
  initial req_o = '0;
  // Released lines carry the inverse so stale values never pass
  task automatic cycle(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
    @(posedge clock_i) #1;
    req_o = '{cs: 1'b1, wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clock_i) #1;
    req_o = '{cs: 1'b0, wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : cycle
endmodule : pmw_host_model

/* sim/power_mgmt_wake_control_bench.sv */
`timescale 1ns/1ps
module power_mgmt_wake_control_bench;
  import pmw_pkg::*;
  localparam int XRST = 10;
  localparam int PULSE = 20;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wake_frame_evt_i = 1'b0;
  logic energy_evt_i = 1'b0;
  pmw_host_req_t host_req;
  logic [31:0] rdata;
  pmw_state_t state;
  logic xrst, ready, pin_out, pin_oe, wake_int;
  int mismatches = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'h0000_9cef;
  logic [31:0] exp_q[$];
  logic rd_seen = 1'b0;

  always #2.5 clock_i = ~clock_i;

  pmw_host_model host (.clock_i(clock_i), .req_o(host_req));

  pmw_power_ctrl #(.XRST_CYCLES(XRST), .PULSE_CYCLES(PULSE),
    .SETTLE_CYCLES(2)) DUT (
    .clock_i(clock_i), .nrst_i(nrst_i), .host_req_i(host_req),
    .wake_frame_evt_i(wake_frame_evt_i), .energy_evt_i(energy_evt_i),
    .host_rdata_o(rdata), .power_state_o(state),
    .transceiver_reset_o(xrst), .device_ready_o(ready),
    .wake_event_out_o(pin_out), .wake_event_oe_o(pin_oe),
    .wake_event_interrupt_o(wake_int));

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift

  // Returns {out, oe} for a given control word and activity
  function automatic logic [1:0] pin(input logic [31:0] c,
                                     input logic act);
    return c[6] ? {act ^ !c[2], 1'b1} : {1'b0, act};
  endfunction : pin

  task automatic conclude();
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  always @(posedge clock_i)
    rd_seen <= host_req.cs && host_req.rd && host_req.addr == 8'h84;

  always @(negedge clock_i) begin
    if (rd_seen === 1'b1 && exp_q.size() > 0)
      check("ctrl read", exp_q.pop_front(), rdata);
  end

  task automatic rd(input logic [31:0] exp);
    exp_q.push_back(exp);
    host.cycle(1'b0, 8'h84, 32'h0);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.cycle(1'b1, a, d);
  endtask : wr

  task automatic wait_ready();
    int i;
    for (i = 0; i < 50 && ready !== 1'b1; i++) @(posedge clock_i);
    if (ready !== 1'b1) begin
      mismatches++;
      conclude();
    end
  endtask : wait_ready

  initial begin
    logic [31:0] cfg;
    logic [1:0] ev;
    logic [1:0] cause;
    int n;
    int k;
    repeat (12) @(posedge clock_i);
    #1 nrst_i = 1'b1;
    wait_ready();
    wr(8'h84, 32'h0000_0302);
    rd(32'h0000_0001);
    rd(32'h0000_0001);
    wr(8'h84, 32'hffff_ffff);
    k = 0;
    fork
      while (xrst === 1'b1 && k < 100) begin
        k++;
        @(posedge clock_i) #1;
      end
      wr(8'h84, 32'h0000_074e);
    join
    check("xrst len", XRST, k);
    rd(32'h0000_034f);
    for (n = 0; n < 8; n++) begin
      cfg = xorshift() & 32'h0000_034e;
      ev = 2'(xorshift() % 32'h3) + 2'h1;
      cause = ev & {cfg[9], cfg[8]};
      wr(8'h84, cfg);
      wake_frame_evt_i = ev[1];
      energy_evt_i = ev[0];
      repeat (2) @(posedge clock_i);
      #1;
      check("irq", {31'h0, |cause}, {31'h0, wake_int});
      check("pin", {30'h0, pin(cfg, |cause & cfg[1])},
            {30'h0, pin_out, pin_oe});
      rd(cfg | {26'h0, cause, 4'h1});
      wr(8'h84, cfg | 32'h30);
      rd(cfg | {26'h0, cause, 4'h1});
      wake_frame_evt_i = 1'b0;
      energy_evt_i = 1'b0;
      wr(8'h84, cfg | 32'h30);
      repeat (PULSE + 5) @(posedge clock_i);
      #1;
      check("pin idle", {30'h0, pin(cfg, 1'b0)},
            {30'h0, pin_out, pin_oe});
      check("irq idle", 32'h0, {31'h0, wake_int});
      rd(cfg | 32'h1);
    end
    wr(8'h84, 32'h0000_1000);
    check("state", {30'h0, PMW_PATTERN_WAKE}, {30'h0, state});
    check("ready", 32'h0, {31'h0, ready});
    rd(32'h0000_1000);
    wr(8'h64, xorshift());
    check("state", {30'h0, PMW_FULL_POWER}, {30'h0, state});
    wait_ready();
    wr(8'h84, 32'h0000_2000);
    check("state", {30'h0, PMW_FULL_POWER}, {30'h0, state});
    rd(32'h0000_0001);
    wr(8'h84, 32'h0000_2000);
    check("state", {30'h0, PMW_ENERGY_DETECT}, {30'h0, state});
    wr(8'h64, xorshift());
    wait_ready();
    repeat (4) @(posedge clock_i);
    check("reads left", 32'h0, exp_q.size());
    conclude();
  end
endmodule : power_mgmt_wake_control_bench
